// file: rtl/floppy_data_separator_precomp.v
// What this block does
// - strobe set on write data leading edge, cleared on phase tap 4 leading edge
// - write gate high disables recovery and floats both pumps
// - pumps may drive only when write gate, vfo enable and read are low
// - each falling read edge, when enabled, judges one pump request
// - edge early in window drives pump up high
// - edge late in window drives pump down low, pump up floats
// - edge in window centre leaves both pumps floating
// - read clock is oscillator divided by 16 single, 8 double density
// - active pump stays on while the read pulse stays low
// - double density: early and late sampled on write data edge pick tap
// - tap 2 nominal, tap 1 early, tap 3 late
// - inner flag low or single density: write data passes straight through
// - density and inner flag control bits reset high, vfo enable bit resets low
// - write data output is the serial precompensated write stream
`include "floppy_support_consts.vh"
`timescale 1ns/1ps
module floppy_data_separator_precomp (
  input wire clock, // system clock, also the sampled oscillator domain
  input wire resetn, // synchronous reset, active low
  input wire vcoIn, // external oscillator, sampled
  input wire rawReadDataN, // raw read pulses from drive, active low
  input wire writeGate, // write gate from controller
  input wire writeDataIn, // write data from controller
  input wire early, // early flag from controller
  input wire late, // late flag from controller
  input wire [3:0] phaseTapN, // delay phase taps 1..4, active low
  output reg readClock, // recovered read clock
  output reg pumpUpOut, // pump up level
  output reg pumpUpOe, // pump up enable, low while driving
  output reg pumpDownOut, // pump down level
  output reg pumpDownOe, // pump down enable, low while driving
  output reg precompStrobe, // strobe to delay generator
  output reg writeDataOut, // precompensated write stream
  input wire [3:0] avsAddress, // avalon byte address
  input wire avsRead, // avalon read
  input wire avsWrite, // avalon write
  input wire [31:0] avsWriteData, // avalon write data
  output reg [31:0] avsReadData, // avalon read data
  output reg avsWaitRequest, // avalon wait request
  output reg [1:0] avsResponse // avalon response, 2'h2 on unmapped
);
  localparam ST_IDLE = 2'h0;
  localparam ST_UP = 2'h1;
  localparam ST_DOWN = 2'h2;
  localparam ST_WAIT = 2'h3;

  reg [2:0] ctrl_q;
  reg vco_q;
  reg [4:0] div_q;
  reg rdd_q;
  reg write_data_in_q;
  reg [3:0] tap_q;
  reg [1:0] pumpState_q;
  reg [1:0] pumpState_d;
  reg [1:0] selTap_q;
  reg [15:0] upCount_q;
  reg [15:0] downCount_q;
  reg [15:0] centreCount_q;
  reg pending_q;
  wire ddenN;
  wire trackFlag;
  wire vfoEnable;
  wire [4:0] divRatio;
  wire vcoRise;
  wire readFall;
  wire wdinRise;
  wire tap4Lead;
  wire recoverOn;
  wire [1:0] edgeClass;
  wire precompOn;
  wire fifoInReady;
  wire fifoOutValid;
  wire [1:0] fifoOutData;
  wire tapLead;

  // classify count phase: 1 early, 2 late, 0 centre
  function [1:0] classify;
    input [4:0] cnt;
    input [4:0] ratio;
    begin
      if (cnt < (ratio >> 2))
        classify = 2'h1;
      else if (cnt >= ratio - (ratio >> 2))
        classify = 2'h2;
      else
        classify = 2'h0;
    end
  endfunction

  // tap index 0..2 chosen from early and late
  function [1:0] pickTap;
    input e;
    input l;
    begin
      if (e)
        pickTap = 2'h0;
      else if (l)
        pickTap = 2'h2;
      else
        pickTap = 2'h1;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // control bits
  assign ddenN = ctrl_q[`FSL_CTRL_DOUBLE_DENSITY_SELECT_N_N];
  assign trackFlag = ctrl_q[`FSL_CTRL_TRACK];
  assign vfoEnable = ctrl_q[`FSL_CTRL_VFOEN];

  // input sampling for edge detection
  always @(posedge clock)
  begin
    if (!resetn)
    begin
      vco_q <= 1'b0;
      rdd_q <= 1'b1;
      write_data_in_q <= 1'b0;
      tap_q <= 4'hf;
    end
    else
    begin
      vco_q <= vcoIn;
      rdd_q <= rawReadDataN;
      write_data_in_q <= writeDataIn;
      tap_q <= phaseTapN;
    end
  end

  assign vcoRise = vcoIn & ~vco_q;
  assign readFall = ~rawReadDataN & rdd_q;
  assign wdinRise = writeDataIn & ~write_data_in_q;
  assign tap4Lead = ~phaseTapN[3] & tap_q[3];

  ////////////////////////////////////////////////////////////////////////
  // divide by density
  assign divRatio = ddenN ? `FSL_DIV_SINGLE : `FSL_DIV_DOUBLE;

  // oscillator divider and read clock
  always @(posedge clock)
  begin
    if (!resetn)
    begin
      div_q <= 5'h00;
      readClock <= 1'b0;
    end
    else if (vcoRise)
    begin
      if (div_q >= (divRatio >> 1) - 5'h01)
      begin
        div_q <= 5'h00;
        readClock <= ~readClock;
      end
      else
        div_q <= div_q + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // recovery enable gating
  assign recoverOn = ~writeGate & ~vfoEnable;
  // phase within half period, scaled to a full ratio
  assign edgeClass = classify({div_q[3:0], 1'b0}, divRatio);

  // pump state machine
  always @*
  begin
    pumpState_d = pumpState_q;
    case (pumpState_q)
      ST_IDLE:
        if (recoverOn && readFall)
        begin
          if (edgeClass == 2'h1)
            pumpState_d = ST_UP;
          else if (edgeClass == 2'h2)
            pumpState_d = ST_DOWN;
          else
            pumpState_d = ST_WAIT;
        end
      ST_UP, ST_DOWN, ST_WAIT:
        // hold while read low and enabled
        if (!recoverOn || rawReadDataN)
          pumpState_d = ST_IDLE;
      default:
        pumpState_d = ST_IDLE;
    endcase
  end

  always @(posedge clock)
  begin
    if (!resetn)
      pumpState_q <= ST_IDLE;
    else
      pumpState_q <= pumpState_d;
  end

  // pump pins from next state, registered
  always @(posedge clock)
  begin
    if (!resetn)
    begin
      pumpUpOut <= 1'b0;
      pumpUpOe <= 1'b1;
      pumpDownOut <= 1'b0;
      pumpDownOe <= 1'b1;
    end
    else
    begin
      pumpUpOut <= 1'b1;
      pumpUpOe <= ~(pumpState_d == ST_UP);
      // pump down driven low, else float
      pumpDownOut <= 1'b0;
      pumpDownOe <= ~(pumpState_d == ST_DOWN);
    end
  end

  // event counters readable by software
  always @(posedge clock)
  begin
    if (!resetn)
    begin
      upCount_q <= 16'h0000;
      downCount_q <= 16'h0000;
      centreCount_q <= 16'h0000;
    end
    else if (pumpState_q == ST_IDLE)
    begin
      if (pumpState_d == ST_UP)
        upCount_q <= upCount_q + 16'h0001;
      if (pumpState_d == ST_DOWN)
        downCount_q <= downCount_q + 16'h0001;
      if (pumpState_d == ST_WAIT)
        centreCount_q <= centreCount_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // precompensation only in double density on inner tracks
  assign precompOn = ~ddenN & trackFlag;

  // tap choices queued per write pulse
  sync_fifo #(
    .WIDTH(`FSL_FIFO_WIDTH),
    .DEPTH(`FSL_FIFO_DEPTH),
    .AW(`FSL_FIFO_AW)
  ) tapQueue (
    .clock(clock),
    .resetn(resetn),
    .inValid(precompOn & wdinRise),
    .inReady(fifoInReady),
    .inData(pickTap(early, late)),
    .outValid(fifoOutValid),
    .outReady(tap4Lead & pending_q),
    .outData(fifoOutData)
  );

  assign tapLead = ~phaseTapN[fifoOutData] & tap_q[fifoOutData];

  // strobe set and clear
  // set wins over a clear in the same cycle
  always @(posedge clock)
  begin
    if (!resetn)
      precompStrobe <= 1'b0;
    else if (wdinRise)
      precompStrobe <= 1'b1;
    else if (tap4Lead)
      precompStrobe <= 1'b0;
  end

  // pending flag and write stream
  always @(posedge clock)
  begin
    if (!resetn)
    begin
      pending_q <= 1'b0;
      selTap_q <= 2'h1;
      writeDataOut <= 1'b0;
    end
    else if (!precompOn)
    begin
      pending_q <= 1'b0;
      writeDataOut <= writeDataIn;
    end
    else
    begin
      pending_q <= fifoOutValid & ~(tap4Lead & pending_q);
      if (fifoOutValid)
        selTap_q <= fifoOutData;
      // chosen tap forms the output pulse
      writeDataOut <= fifoOutValid & pending_q & ~phaseTapN[selTap_q];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, answer on second cycle
  always @(posedge clock)
  begin
    if (!resetn)
    begin
      ctrl_q <= `FSL_CTRL_RESET;
      avsWaitRequest <= 1'b1;
      avsReadData <= 32'h00000000;
      avsResponse <= 2'h0;
    end
    else
    begin
      avsWaitRequest <= ~((avsRead | avsWrite) & avsWaitRequest);
      // write lands at the edge that sees wait request low
      if (avsWrite && !avsWaitRequest && avsAddress == `FSL_ADDR_CTRL)
        ctrl_q <= avsWriteData[2:0];
      if ((avsRead | avsWrite) && avsWaitRequest)
      begin
        avsResponse <= 2'h0;
        avsReadData <= 32'h00000000;
        case (avsAddress)
          `FSL_ADDR_CTRL:
            avsReadData <= {29'h0, ctrl_q};
          `FSL_ADDR_STATUS:
            avsReadData <= {25'h0, tapLead, fifoOutValid, readClock, precompStrobe,
              ~pumpDownOe, ~pumpUpOe, recoverOn};
          `FSL_ADDR_COUNT:
            avsReadData <= {upCount_q[9:0], downCount_q[9:0], centreCount_q[11:0]};
          default:
            avsResponse <= 2'h2;
        endcase
      end
      else
        avsWaitRequest <= 1'b1;
    end
  end
endmodule

// file: rtl/sync_fifo.v
`timescale 1ns/1ps
module sync_fifo #(
  parameter WIDTH = 2,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clock, // system clock
  input wire resetn, // synchronous reset, active low
  input wire inValid, // write side offers a word
  output wire inReady, // space free
  input wire [WIDTH-1:0] inData, // word written
  output wire outValid, // word available
  input wire outReady, // read side takes the word
  output wire [WIDTH-1:0] outData // head word
);
  localparam [AW:0] FULL_COUNT = DEPTH;
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_q;
  reg [AW-1:0] rdPtr_q;
  reg [AW:0] count_q;
  wire doWrite;
  wire doRead;
  assign inReady = (count_q != FULL_COUNT);
  assign outValid = (count_q != {(AW+1){1'b0}});
  assign outData = mem[rdPtr_q];
  assign doWrite = inValid & inReady;
  assign doRead = outValid & outReady;
  // pointers and occupancy
  always @(posedge clock)
  begin
    if (!resetn)
    begin
      wrPtr_q <= {AW{1'b0}};
      rdPtr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end
    else
    begin
      if (doWrite)
        wrPtr_q <= wrPtr_q + 1'b1;
      if (doRead)
        rdPtr_q <= rdPtr_q + 1'b1;
      if (doWrite && !doRead)
        count_q <= count_q + 1'b1;
      else if (doRead && !doWrite)
        count_q <= count_q - 1'b1;
    end
  end
  // storage
  always @(posedge clock)
  begin
    if (doWrite)
      mem[wrPtr_q] <= inData;
  end
endmodule

// file: shared/floppy_support_consts.vh
`ifndef FLOPPY_SUPPORT_CONSTS_VH
`define FLOPPY_SUPPORT_CONSTS_VH
// register byte addresses
`define FSL_ADDR_CTRL 4'h0
`define FSL_ADDR_STATUS 4'h4
`define FSL_ADDR_COUNT 4'h8
// control register field positions
`define FSL_CTRL_DOUBLE_DENSITY_SELECT_N_N 0
`define FSL_CTRL_TRACK 1
`define FSL_CTRL_VFOEN 2
// control register reset value: double density off, inner track flag high
`define FSL_CTRL_RESET 3'h3
// oscillator divide ratios, oscillator rises per full read clock period; the divider counts half of each
`define FSL_DIV_SINGLE 5'h10
`define FSL_DIV_DOUBLE 5'h08
// fifo shape
`define FSL_FIFO_WIDTH 2
`define FSL_FIFO_DEPTH 16
`define FSL_FIFO_AW 4
`endif

// file: sim/far_side_model.sv
`timescale 1ns/1ps
module far_side_model (
  input logic clock, // clock
  input logic precompStrobe, // strobe
  output logic vcoIn, // oscillator
  output logic [3:0] phaseTapN // taps, active low
);
  int div = 0;
  int ph = 0;
  initial
  begin
    vcoIn = 0;
    phaseTapN = 4'hf;
  end
  // nominal clock
  // 4 MHz oscillator, ten clocks a period
  always @(posedge clock)
  begin
    div <= (div == 4) ? 0 : div + 1;
    if (div == 4)
      vcoIn <= !vcoIn;
  end
  // delay generator: taps one to four fall in turn, three cycles each
  always @(posedge clock)
  begin
    if (ph == 0 && precompStrobe)
      ph <= 1;
    else if (ph != 0)
      ph <= (ph == 14) ? 0 : ph + 1;
    if (ph >= 2 && ph <= 13)
      phaseTapN <= ~(4'h1 << ((ph - 2) / 3));
    else
      phaseTapN <= 4'hf;
  end
endmodule

// file: sim/fdsp_chk.sv
`timescale 1ns/1ps
module fdsp_chk (
  input logic clock, // clock
  input logic resetn, // reset
  input logic rawReadDataN, // read
  input logic writeGate, // gate
  input logic writeDataIn, // write data
  input logic [3:0] phaseTapN, // taps
  input logic pumpUpOut, // up level
  input logic pumpUpOe, // up enable
  input logic pumpDownOut, // down level
  input logic pumpDownOe, // down enable
  input logic precompStrobe, // strobe
  input logic avsRead, // bus read
  input logic avsWaitRequest // bus wait
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // steps of a strobe cycle and of an active read
  sequence wrLead; $rose(writeDataIn); endsequence
  sequence tapFour; $fell(phaseTapN[3]); endsequence
  sequence readOn; !rawReadDataN && !writeGate; endsequence
  // pump enables against their causes
  gate_float_a: assert property (writeGate |=> pumpUpOe && pumpDownOe)
    else $error("pump driven under write gate");
  pump_cause_a: assert property (!(pumpUpOe && pumpDownOe) |-> $past(!rawReadDataN && !writeGate))
    else $error("pump driven without read");
  one_pump_a: assert property (pumpUpOe || pumpDownOe)
    else $error("both pumps driven");
  pump_level_a: assert property ((pumpUpOe || pumpUpOut) && (pumpDownOe || !pumpDownOut))
    else $error("pump level wrong");
  pump_hold_a: assert property (!pumpUpOe ##0 readOn |=> !pumpUpOe)
    else $error("pump up dropped early");
  pump_free_a: assert property (rawReadDataN |=> pumpUpOe && pumpDownOe)
    else $error("pump not released");
  // strobe set and clear
  strobe_set_a: assert property (wrLead |=> precompStrobe)
    else $error("strobe not set");
  strobe_clear_a: assert property (tapFour |=> !precompStrobe)
    else $error("strobe not cleared");
  wait_answer_a: assert property (avsRead && avsWaitRequest |=> !avsWaitRequest)
    else $error("bus read not answered");
endmodule
bind floppy_data_separator_precomp fdsp_chk u_chk (.clock, .resetn, .rawReadDataN,
  .writeGate, .writeDataIn, .phaseTapN, .pumpUpOut, .pumpUpOe, .pumpDownOut,
  .pumpDownOe, .precompStrobe, .avsRead, .avsWaitRequest);

// file: sim/testbench.sv
`timescale 1ns/1ps
`include "floppy_support_consts.vh"
module testbench;
  logic clock = 0, resetn = 0, rawReadDataN = 1, writeGate = 0, writeDataIn = 0;
  logic early = 0, late = 0, avsRead = 0, avsWrite = 0, vcoIn, readClock;
  logic pumpUpOut, pumpUpOe, pumpDownOut, pumpDownOe, precompStrobe, writeDataOut;
  logic avsWaitRequest;
  logic [3:0] phaseTapN, avsAddress = 4'h0;
  logic [31:0] avsWriteData = 32'h0, avsReadData, rd;
  logic [1:0] avsResponse, rs;
  int badCount = 0, checked = 0, cyc = 0;
  floppy_data_separator_precomp DUT (.clock, .resetn, .vcoIn, .rawReadDataN, .writeGate,
    .writeDataIn, .early, .late, .phaseTapN, .readClock, .pumpUpOut, .pumpUpOe,
    .pumpDownOut, .pumpDownOe, .precompStrobe, .writeDataOut, .avsAddress, .avsRead,
    .avsWrite, .avsWriteData, .avsReadData, .avsWaitRequest, .avsResponse);
  far_side_model farSide (.clock, .precompStrobe, .vcoIn, .phaseTapN);
  // 40 MHz clock
  initial
  begin
    forever #12.5 clock = ~clock;
  end
  // hang guard
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 12000)
    begin
      badCount++;
      wrap_up;
    end
  end
  ////////////////////////////////////////////////////////////
  task wrap_up;
    if (badCount == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      badCount++;
      $display("ERROR %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // one bus access, held until wait request is seen low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    avsAddress <= a;
    avsWrite <= w;
    avsRead <= !w;
    avsWriteData <= d;
    do @(posedge clock); while (avsWaitRequest !== 1'b0);
    rd = avsReadData;
    rs = avsResponse;
    avsRead <= 0;
    avsWrite <= 0;
  endtask
  task waitRc(input logic lvl);
    while (readClock !== !lvl) @(posedge clock);
    while (readClock !== lvl) @(posedge clock);
  endtask
  task vcoRises(input int n);
    logic pv;
    pv = vcoIn;
    while (n > 0)
    begin
      @(posedge clock);
      if (vcoIn && !pv)
        n--;
      pv = vcoIn;
    end
  endtask
  ////////////////////////////////////////////////////////////
  task t_regs;
    bus(0, `FSL_ADDR_CTRL, 0);
    chk(rd, `FSL_CTRL_RESET, "ctrl reset");
    bus(0, 4'hc, 0);
    chk(rs, 2'h2, "unmapped response");
    chk(rd, 0, "unmapped data");
    bus(1, `FSL_ADDR_CTRL, 32'h6);
    bus(0, `FSL_ADDR_CTRL, 0);
    chk(rd, 32'h6, "ctrl readback");
  endtask
  task t_divide(input logic [31:0] ctrl, input int half);
    int n;
    logic pv;
    bus(1, `FSL_ADDR_CTRL, ctrl);
    waitRc(0);
    waitRc(1);
    n = 0;
    pv = vcoIn;
    while (readClock === 1'b1)
    begin
      @(posedge clock);
      if (vcoIn && !pv)
        n++;
      pv = vcoIn;
    end
    chk(n, half, "read clock half period");
  endtask
  // read pulse placed n oscillator rises after a read clock edge
  task t_pump(input logic gate, input logic fall, input int n, input logic [1:0] expOe);
    waitRc(!fall);
    vcoRises(n);
    writeGate <= gate;
    rawReadDataN <= 0;
    tick(4);
    chk({pumpUpOe, pumpDownOe}, expOe, "pump enables");
    rawReadDataN <= 1;
    tick(3);
    chk({pumpUpOe, pumpDownOe}, 2'b11, "pump release");
    writeGate <= 0;
  endtask
  task t_precomp(input logic e, input logic l, input int tap);
    logic pd;
    early <= e;
    late <= l;
    tick(4);
    writeDataIn <= 1;
    tick(2);
    writeDataIn <= 0;
    pd = 0;
    repeat (24)
    begin
      @(posedge clock);
      chk(writeDataOut, pd, "precomp output");
      pd = !phaseTapN[tap];
    end
  endtask
  task t_bypass(input logic [31:0] ctrl);
    logic pv;
    bus(1, `FSL_ADDR_CTRL, ctrl);
    writeDataIn <= 1;
    pv = 0;
    repeat (6)
    begin
      @(posedge clock);
      chk(writeDataOut, pv, "bypass output");
      pv = writeDataIn;
      if (pv)
        writeDataIn <= 0;
    end
    tick(20);
  endtask
  ////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    tick(6);
    resetn <= 1;
    t_regs;
    t_divide(32'h3, 8);
    t_divide(32'h2, 4);
    bus(1, `FSL_ADDR_CTRL, 32'h3);
    t_pump(0, 0, 1, 2'b01);
    t_pump(0, 0, 4, 2'b11);
    t_pump(0, 1, 6, 2'b10);
    t_pump(1, 0, 1, 2'b11);
    bus(1, `FSL_ADDR_CTRL, 32'h7);
    t_pump(0, 0, 1, 2'b11);
    bus(0, `FSL_ADDR_COUNT, 0);
    chk(rd, 32'h00401001, "pump event counts");
    bus(1, `FSL_ADDR_CTRL, 32'h2);
    t_precomp(1, 0, 0);
    t_precomp(0, 1, 2);
    t_precomp(0, 0, 1);
    t_bypass(32'h0);
    t_bypass(32'h3);
    wrap_up;
  end
endmodule
